// [design/adc_rb_pkg.sv]
/*
 * Constants shared by the serial readback block: command codes, register
 * addresses, restart masks, register reset values and sequencer states.
 * Assumes an 18-entry byte-wide configuration register file.
 */
package adc_rb_pkg;

	localparam int          REG_COUNT    = 18;
	localparam int          ADDR_W       = 5;
	localparam int          SYNC_STAGES  = 3;
	localparam int          RES_BYTES    = 3;

	// Command first-byte decoding
	localparam logic [7:0]  CMD_RDATA    = 8'h12;
	localparam logic [7:0]  CMD_RDATA_M  = 8'hfe;
	localparam logic [2:0]  OP_REG_READ_CMD      = 3'h1;
	localparam logic [2:0]  OP_REG_WRITE_CMD      = 3'h2;

	// Registers whose writes can restart a conversion
	localparam logic [4:0]  A_INPMUX     = 5'h02;
	localparam logic [4:0]  A_PGA        = 5'h03;
	localparam logic [4:0]  A_DATARATE   = 5'h04;
	localparam logic [4:0]  A_REF        = 5'h05;
	localparam logic [4:0]  A_IDACMAG    = 5'h06;
	localparam logic [4:0]  A_IDACMUX    = 5'h07;
	localparam logic [4:0]  A_SYS        = 5'h09;
	localparam logic [7:0]  M_FULL       = 8'hff;
	localparam logic [7:0]  M_REF        = 8'h3f;
	localparam logic [7:0]  M_IDACMAG    = 8'h0f;
	localparam logic [7:0]  M_SYS        = 8'he0;
	localparam logic [7:0]  M_NONE       = 8'h00;

	// Readback framing enables in the system register
	localparam int          SYS_STAT_BIT = 0;
	localparam int          SYS_CRC_BIT  = 1;

	// Identification value is arbitrary
	localparam logic [7:0]  ID_VALUE     = 8'h00;

	localparam logic [7:0]  REG_RST [REG_COUNT] = '{
		ID_VALUE, 8'h80, 8'h01, 8'h00, 8'h14, 8'h10, 8'h00, 8'hff, 8'h00,
		8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00};

	typedef enum logic [2:0] {
		C_IDLE    = 3'b000,
		C_RR_CNT  = 3'b001,
		C_WR_CNT  = 3'b010,
		C_WR_DATA = 3'b011,
		C_BLOCK   = 3'b100
	} cmd_state_t;

	typedef enum logic [1:0] {
		SRC_DIRECT = 2'b00,
		SRC_HOLD   = 2'b01,
		SRC_REG    = 2'b10
	} out_src_t;

endpackage : adc_rb_pkg

// [design/wr_check_if.sv]
/*
 * Carrier between the sequencer and the restart comparator.
 * Assumes both ends sit in the same clock domain.
 */
interface wr_check_if;
	logic [4:0] addr;
	logic [7:0] new_val;
	logic [7:0] old_val;
	logic       changed;

	modport src (output addr, output new_val, output old_val, input changed);
	modport chk (input addr, input new_val, input old_val, output changed);
endinterface : wr_check_if

// [design/pin_sync.sv]
/*
 * Three-stage synchroniser for asynchronous pins, with filtered level and
 * edge pulses. Assumes pins are slow against i_clk.
 */
module pin_sync
	import adc_rb_pkg::*;
#(
	parameter int W = 3
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_pin,
	output logic      [W-1:0] o_lvl,
	output logic      [W-1:0] o_rise,
	output logic      [W-1:0] o_fall
);

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic [SYNC_STAGES-1:0] st_r;
			logic                   lvl_r;
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					st_r  <= '0;
					lvl_r <= 1'b0;
				end else begin
					st_r <= {st_r[SYNC_STAGES-2:0], i_pin[g]};
					// Only the two later stages vote
					if (st_r[1] == st_r[2])
						lvl_r <= st_r[2];
				end
			end
			assign o_lvl[g]  = lvl_r;
			assign o_rise[g] = st_r[1] & st_r[2] & ~lvl_r;
			assign o_fall[g] = ~st_r[1] & ~st_r[2] & lvl_r;
		end
	endgenerate

endmodule : pin_sync

// [design/restart_check.sv]
/*
 * Compares a written byte with the stored one over the bits that restart a
 * conversion. Assumes addr/new/old are stable in the write cycle.
 */
module restart_check
	import adc_rb_pkg::*;
(
	wr_check_if.chk w
);

	logic [7:0] mask;

	always_comb begin
		if (w.addr == A_INPMUX || w.addr == A_PGA || w.addr == A_DATARATE)
			mask = M_FULL;
		else if (w.addr == A_REF)
			mask = M_REF;
		else if (w.addr == A_IDACMAG)
			mask = M_IDACMAG;
		else if (w.addr == A_IDACMUX)
			mask = M_FULL;
		else if (w.addr == A_SYS)
			mask = M_SYS;
		else
			mask = M_NONE;
	end

	assign w.changed = |((w.new_val ^ w.old_val) & mask);

endmodule : restart_check

// [design/adc_serial_readback.sv]
/*
 * Serial readback and command front end of a delta-sigma converter:
 * direct and command readback, register access, write-driven restarts and
 * the data-ready pins. Assumes a conversion core that supplies results and
 * honours the restart pulse; chip select, serial clock and data in arrive
 * asynchronously and are slow against i_clk.
 */
// Contract
// - Writing channel, gain or data-rate register restarts a running conversion.
// - Restart also on reference bits 5:0, current-1 bits 3:0, current-2 any bit.
// - System register bits 7:5 restart; its other bits never do.
// - After restart, drop the old result; ready only after new conversion.
// - Restart only if value changed and a conversion is running.
// - In standby apply writes without converting; start awaits pin or command.
// - Each result loads output register and holding register; commands read holding.
// - Direct readback decodes data-in bytes as commands; host holds data-in low.
// - Dedicated ready pin returns high on first falling serial-clock edge.
// - Read-data command shifts holding register MSB first from next rising edge.
// - Field is optional status, three result bytes, optional check byte.
// - One read-data command per readback; others ignored until done or deselect.
// - Continued clocking repeats the whole byte sequence.
// - Commands are accepted only on 8-bit byte boundaries.
// - Register or data read mid-readback aborts it; new data from next rise.
// - Write during readback keeps data; restart after each written data byte.
// - Output buffer is cyclic; first byte reappears with fourth input byte.
// - Deselected, combined pin floats; dedicated ready pin stays driven.
// - On select, combined pin shows low for unread data, else high.
// - Register read is 001 plus address, then 000 plus count minus one.
// - Register write is 010 plus address, count byte, then data MSB first.
// - Results are not loaded into output register during register access.
module adc_serial_readback
	import adc_rb_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_cs_n,
	input  wire logic        i_sclk,
	input  wire logic        i_din,
	input  wire logic        i_converting,
	input  wire logic        i_conv_done,
	input  wire logic [23:0] i_conv_result,
	input  wire logic [7:0]  i_conv_status,
	input  wire logic [7:0]  i_conv_crc,
	output logic             o_serial_out_with_ready,
	output logic             o_serial_out_oe,
	output logic             o_result_ready_n,
	output logic             o_filter_restart,
	output logic             o_other_cmd_valid,
	output logic [7:0]       o_other_cmd,
	output logic             o_cfg_wr,
	output logic [4:0]       o_cfg_addr,
	output logic [7:0]       o_cfg_data
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	logic [2:0] lvl;
	logic [2:0] rise;
	logic [2:0] fall;

	// Select is inverted so a cleared synchroniser matches an idle bus
	pin_sync #(.W(3)) u_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_pin   ({i_din, i_sclk, ~i_cs_n}),
		.o_lvl   (lvl),
		.o_rise  (rise),
		.o_fall  (fall)
	);

	logic sel;
	logic sck_rise;
	logic sck_fall;
	logic din;

	assign sel      = lvl[0];
	assign sck_rise = rise[1] & sel;
	assign sck_fall = fall[1] & sel;
	assign din      = lvl[2];

	////////////////////////////////////////////////////////////////////////
	// State

	cmd_state_t mode_r;
	out_src_t   src_r;
	logic [6:0] rx_r;
	logic [2:0] rbit_r;
	logic [2:0] tbit_r;
	logic [7:0] tx_r;
	logic       tx_last_r;
	logic [2:0] bidx_r;
	logic [4:0] addr_r;
	logic [4:0] cnt_r;
	logic       started_r;
	logic       result_ready_n_n_r;
	logic       pin_r;
	logic       restart_r;
	logic [23:0] dir_res_r;
	logic [7:0]  dir_st_r;
	logic [7:0]  dir_crc_r;
	logic [23:0] hold_res_r;
	logic [7:0]  hold_st_r;
	logic [7:0]  hold_crc_r;
	logic [7:0]  regs_r [REG_COUNT];

	////////////////////////////////////////////////////////////////////////
	// Byte assembly and field framing

	logic       byte_done;
	logic [7:0] byte_in;
	logic       st_en;
	logic       crc_en;
	logic [2:0] field_len;
	logic [2:0] bidx_nxt;
	logic       addr_ok;
	logic       reg_busy;

	// Commands complete only on whole bytes
	assign byte_done = sck_fall && rbit_r == 3'h7;
	assign byte_in   = {rx_r, din};
	assign st_en     = regs_r[A_SYS][SYS_STAT_BIT];
	assign crc_en    = regs_r[A_SYS][SYS_CRC_BIT];
	assign field_len = 3'(RES_BYTES) + {2'h0, st_en} + {2'h0, crc_en};
	assign bidx_nxt  = (bidx_r == field_len - 3'h1) ? 3'h0 : bidx_r + 3'h1;
	assign addr_ok   = addr_r < 5'(REG_COUNT);
	assign reg_busy  = mode_r == C_RR_CNT || mode_r == C_WR_CNT
		|| mode_r == C_WR_DATA || src_r == SRC_REG;

	function automatic logic [7:0] pick(
		input logic [7:0]  st,
		input logic [23:0] res,
		input logic [7:0]  crc,
		input logic [2:0]  idx,
		input logic        s_en
	);
		logic [2:0] k;
		k = s_en ? idx : idx + 3'h1;
		case (k)
			3'h0:    pick = st;
			3'h1:    pick = res[23:16];
			3'h2:    pick = res[15:8];
			3'h3:    pick = res[7:0];
			default: pick = crc;
		endcase
	endfunction : pick

	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !sel) begin
			rx_r   <= '0;
			rbit_r <= '0;
		end else if (sck_fall) begin
			rx_r   <= byte_in[6:0];
			rbit_r <= rbit_r + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Restart comparison

	wr_check_if wc ();
	assign wc.addr    = addr_r;
	assign wc.new_val = byte_in;
	assign wc.old_val = addr_ok ? regs_r[addr_r] : 8'h00;

	restart_check u_chk (
		.w (wc.chk)
	);

	logic wr_byte;
	logic do_restart;

	assign wr_byte    = byte_done && mode_r == C_WR_DATA && addr_ok;
	// Standby writes only store the value
	assign do_restart = wr_byte && wc.changed && i_converting;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			restart_r  <= 1'b0;
			o_cfg_wr   <= 1'b0;
			o_cfg_addr <= '0;
			o_cfg_data <= '0;
		end else begin
			restart_r  <= do_restart;
			o_cfg_wr   <= wr_byte;
			o_cfg_addr <= addr_r;
			o_cfg_data <= byte_in;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			regs_r <= REG_RST;
		end else if (wr_byte) begin
			regs_r[addr_r] <= byte_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command decode and output sequencing

	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !sel) begin
			mode_r            <= C_IDLE;
			src_r             <= SRC_DIRECT;
			tbit_r            <= '0;
			tx_r              <= '0;
			tx_last_r         <= 1'b0;
			bidx_r            <= '0;
			addr_r            <= '0;
			cnt_r             <= '0;
			o_other_cmd_valid <= 1'b0;
			o_other_cmd       <= '0;
		end else begin
			o_other_cmd_valid <= 1'b0;
			if (sck_rise) begin
				tbit_r <= tbit_r + 3'h1;
				if (tbit_r == 3'h0) begin
					case (src_r)
						SRC_DIRECT: begin
							tx_r      <= pick(dir_st_r, dir_res_r, dir_crc_r, bidx_r, st_en);
							tx_last_r <= bidx_nxt == 3'h0;
							bidx_r    <= bidx_nxt;
						end
						SRC_HOLD: begin
							tx_r      <= pick(hold_st_r, hold_res_r, hold_crc_r, bidx_r, st_en);
							tx_last_r <= bidx_nxt == 3'h0;
							bidx_r    <= bidx_nxt;
						end
						default: begin
							tx_r      <= addr_ok ? regs_r[addr_r] : 8'h00;
							tx_last_r <= cnt_r == 5'h0;
							addr_r    <= addr_r + 5'h1;
							cnt_r     <= cnt_r - 5'h1;
						end
					endcase
				end else begin
					tx_r <= {tx_r[6:0], 1'b0};
				end
			end else if (byte_done) begin
				case (mode_r)
					C_IDLE: begin
						// Direct readback is full duplex
						if ((byte_in & CMD_RDATA_M) == CMD_RDATA) begin
							src_r  <= SRC_HOLD;
							bidx_r <= '0;
							mode_r <= C_BLOCK;
						end else if (byte_in[7:5] == OP_REG_READ_CMD) begin
							addr_r <= byte_in[4:0];
							mode_r <= C_RR_CNT;
						end else if (byte_in[7:5] == OP_REG_WRITE_CMD) begin
							addr_r <= byte_in[4:0];
							mode_r <= C_WR_CNT;
						end else if (byte_in != 8'h00) begin
							o_other_cmd_valid <= 1'b1;
							o_other_cmd       <= byte_in;
						end
					end
					C_RR_CNT: begin
						cnt_r  <= byte_in[4:0];
						src_r  <= SRC_REG;
						mode_r <= C_BLOCK;
					end
					C_WR_CNT: begin
						cnt_r  <= byte_in[4:0];
						mode_r <= C_WR_DATA;
					end
					C_WR_DATA: begin
						// Output source untouched, readback continues
						addr_r <= addr_r + 5'h1;
						cnt_r  <= cnt_r - 5'h1;
						if (cnt_r == 5'h0)
							mode_r <= C_IDLE;
					end
					default: begin
						// Other commands ignored until the field is out
						if (tx_last_r)
							mode_r <= C_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Result capture

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			hold_res_r <= '0;
			hold_st_r  <= '0;
			hold_crc_r <= '0;
		end else if (i_conv_done) begin
			hold_res_r <= i_conv_result;
			hold_st_r  <= i_conv_status;
			hold_crc_r <= i_conv_crc;
		end
	end

	// Late reads lose the old result
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			dir_res_r <= '0;
			dir_st_r  <= '0;
			dir_crc_r <= '0;
		end else if (i_conv_done && !reg_busy) begin
			dir_res_r <= i_conv_result;
			dir_st_r  <= i_conv_status;
			dir_crc_r <= i_conv_crc;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data-ready pins

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			result_ready_n_n_r <= 1'b1;
		end else if (i_conv_done) begin
			// A new result beats a same-cycle clear
			result_ready_n_n_r <= 1'b0;
		end else if (do_restart) begin
			result_ready_n_n_r <= 1'b1;
		end else if (sck_fall) begin
			result_ready_n_n_r <= 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !sel) begin
			started_r <= 1'b0;
		end else if (sck_rise) begin
			started_r <= 1'b1;
		end else if (i_conv_done && mode_r == C_IDLE && tbit_r == 3'h0
			&& src_r == SRC_DIRECT) begin
			// Tied-low select: combined pin shows ready again
			started_r <= 1'b0;
		end
	end

	// Shift data keeps its last bit so a polling host can park it high
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pin_r <= 1'b1;
		end else begin
			pin_r <= started_r ? tx_r[7] : result_ready_n_n_r;
		end
	end

	assign o_serial_out_with_ready = pin_r;
	assign o_serial_out_oe         = sel;
	assign o_result_ready_n        = result_ready_n_n_r;
	assign o_filter_restart        = restart_r;

endmodule : adc_serial_readback

// [bench/adc_rb_monitor.sv]
/*
 * Port checker for the serial readback block.
 * Assumes it is bound to adc_serial_readback and sees only its ports.
 */
module adc_rb_monitor (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_cs_n,
	input wire logic i_sclk,
	input wire logic i_converting,
	input wire logic i_conv_done,
	input wire logic o_serial_out_with_ready,
	input wire logic o_serial_out_oe,
	input wire logic o_result_ready_n,
	input wire logic o_filter_restart,
	input wire logic o_cfg_wr
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	////////////////////////////////////////////////////////////////////////
	property p_done_ready; i_conv_done |=> !o_result_ready_n; endproperty
	a_done_ready: assert property (p_done_ready)
		else $error("ready not set after a result");
	// Sync delay plus output flop, two cycles spare
	property p_sclk_ready;
		$fell(i_sclk) && !i_cs_n && !o_result_ready_n |-> ##[1:6] o_result_ready_n;
	endproperty
	a_sclk_ready: assert property (p_sclk_ready)
		else $error("ready stayed low after serial clock fall");
	property p_oe_off; i_cs_n [*6] |-> !o_serial_out_oe; endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("combined pin driven while deselected");
	property p_oe_on; !i_cs_n [*6] |-> o_serial_out_oe; endproperty
	a_oe_on: assert property (p_oe_on)
		else $error("combined pin not driven while selected");
	property p_pin_ready;
		$fell(i_cs_n) ##6 !i_cs_n |-> o_serial_out_with_ready == o_result_ready_n;
	endproperty
	a_pin_ready: assert property (p_pin_ready)
		else $error("combined pin does not show ready on select");

	////////////////////////////////////////////////////////////////////////
	property p_restart_conv; o_filter_restart |-> $past(i_converting); endproperty
	a_restart_conv: assert property (p_restart_conv)
		else $error("restart while not converting");
	property p_restart_ready;
		// A result in the restart cycle itself wins
		o_filter_restart && !$past(i_conv_done) && !i_conv_done |=> o_result_ready_n;
	endproperty
	a_restart_ready: assert property (p_restart_ready)
		else $error("old result still flagged after restart");
	property p_restart_cfg; o_filter_restart |-> o_cfg_wr || $past(o_cfg_wr); endproperty
	a_restart_cfg: assert property (p_restart_cfg)
		else $error("restart without a register write");
	property p_cfg_pulse; o_cfg_wr |=> !o_cfg_wr; endproperty
	a_cfg_pulse: assert property (p_cfg_pulse)
		else $error("register write pulse too long");
endmodule : adc_rb_monitor

// [bench/adc_rb_host.sv]
/*
 * Behavioural serial bus controller facing the readback block.
 * Assumes the combined pin arrives resolved, pulled up when released.
 */
module adc_rb_host (
	output logic      o_cs_n,
	output logic      o_sclk,
	output logic      o_din,
	input  wire logic i_so
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_din  = 1'b0;
	end

	// Odd offset keeps the link out of phase with the core clock
	task automatic sel();
		#13 o_cs_n = 1'b0;
		#320;
	endtask : sel

	task automatic desel();
		#160 o_cs_n = 1'b1;
		o_din = 1'b0;
		#480;
	endtask : desel

	// Sample late in the low phase: pin lags the rise by up to 5 clocks
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			o_din = tx[i];
			o_sclk = 1'b1;
			#160 o_sclk = 1'b0;
			#160 rx[i] = i_so;
		end
	endtask : xfer
endmodule : adc_rb_host

// [bench/test_adc_serial_readback.sv]
/*
 * Self-checking bench for the serial readback block.
 * Assumes the host model and checker files are compiled first.
 */
module test_adc_serial_readback;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, rst_n = 1'b0, conv = 1'b0, done = 1'b0;
	logic [23:0] res = 24'h000000;
	logic        cs_n, sclk, din, pin, oe, rdy_n, restart, cfg_wr;
	logic [4:0]  cfg_a, cfg_av;
	logic [7:0]  cfg_d, cfg_v, oth;
	logic [7:0]  oth_c = 8'h00;
	logic        oth_v;
	wire         so = oe ? pin : 1'b1;
	int          bad_count = 0, checks_done = 0, n_rs = 0;

	always #20 clk = ~clk;
	always @(posedge clk) begin
		if (restart === 1'b1) n_rs++;
		if (cfg_wr === 1'b1) begin
			cfg_v = cfg_d;
			cfg_av = cfg_a;
		end
		if (oth_v === 1'b1) oth_c = oth;
	end

	adc_serial_readback u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n),
		.i_sclk(sclk), .i_din(din), .i_converting(conv), .i_conv_done(done),
		.i_conv_result(res), .i_conv_status(8'h5a), .i_conv_crc(8'h3c),
		.o_serial_out_with_ready(pin), .o_serial_out_oe(oe),
		.o_result_ready_n(rdy_n), .o_filter_restart(restart),
		.o_other_cmd_valid(oth_v), .o_other_cmd(oth), .o_cfg_wr(cfg_wr),
		.o_cfg_addr(cfg_a), .o_cfg_data(cfg_d));
	adc_rb_host u_host (.o_cs_n(cs_n), .o_sclk(sclk), .o_din(din), .i_so(so));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_sim

	task automatic result(input logic [23:0] r);
		@(negedge clk) begin
			done = 1'b1;
			res = r;
		end
		@(negedge clk) done = 1'b0;
		repeat (2) @(negedge clk);
		check(rdy_n, 1'b0);
	endtask : result

	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		logic [7:0] rx;
		u_host.sel();
		u_host.xfer({3'h2, a}, rx);
		u_host.xfer(8'h00, rx);
		u_host.xfer(v, rx);
		u_host.desel();
	endtask : wr

	////////////////////////////////////////////////////////////////////////
	// Direct readback with a write slipped in on the data-in line
	task automatic s_direct();
		logic [7:0] rx;
		int         n0;
		n0 = n_rs;
		result(24'ha5c30f);
		u_host.sel();
		check(so, 1'b0);
		u_host.xfer(8'h42, rx);
		check(rx, 8'ha5);
		check(rdy_n, 1'b1);
		u_host.xfer(8'h00, rx);
		check(rx, 8'hc3);
		u_host.xfer(8'h23, rx);
		check(rx, 8'h0f);
		u_host.xfer(8'h00, rx);
		check(rx, 8'ha5);
		// Readback ends well before any new result
		u_host.desel();
		check(oe, 1'b0);
		check(8'(n_rs - n0), 8'h01);
	endtask : s_direct

	task automatic s_rdata();
		logic [7:0] rx;
		logic [7:0] e [6] = '{8'h12, 8'h34, 8'h56, 8'h12, 8'h34, 8'h56};
		logic [7:0] t [6] = '{8'h20, 8'h00, 8'h12, 8'h00, 8'h00, 8'h00};
		result(24'h123456);
		u_host.sel();
		u_host.xfer(8'h12, rx);
		// Read commands on the first and on the last (third) byte are both ignored; the field repeats
		for (int i = 0; i < 6; i++) begin
			u_host.xfer(t[i], rx);
			check(rx, e[i]);
		end
		u_host.desel();
	endtask : s_rdata

	task automatic s_status();
		logic [7:0] rx;
		logic [7:0] e [6] = '{8'h5a, 8'hfe, 8'hdc, 8'hba, 8'h3c, 8'h5a};
		int         n0;
		n0 = n_rs;
		wr(5'h09, 8'h13);
		check(8'(n_rs - n0), 8'h00);
		result(24'hfedcba);
		u_host.sel();
		u_host.xfer(8'h12, rx);
		for (int i = 0; i < 6; i++) begin
			u_host.xfer(8'h00, rx);
			check(rx, e[i]);
		end
		u_host.desel();
	endtask : s_status

	task automatic s_restart();
		logic [7:0] rx;
		logic [4:0] a [11] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h05, 5'h06, 5'h06,
			5'h07, 5'h09, 5'h08, 5'h03};
		logic [7:0] v [11] = '{8'h23, 8'h05, 8'h15, 8'h50, 8'h11, 8'h10, 8'h01,
			8'hfe, 8'h33, 8'h55, 8'h07};
		logic [7:0] e [11] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01,
			8'h01, 8'h01, 8'h00, 8'h00};
		int         n0;
		for (int i = 0; i < 11; i++) begin
			@(negedge clk) conv = (i < 10);
			n0 = n_rs;
			wr(a[i], v[i]);
			check(8'(n_rs - n0), e[i]);
			check(cfg_v, v[i]);
			check({3'h0, cfg_av}, {3'h0, a[i]});
		end
		// Two-register read ending on a value with its low bit set
		u_host.sel();
		u_host.xfer(8'h25, rx);
		u_host.xfer(8'h01, rx);
		u_host.xfer(8'h00, rx);
		check(rx, 8'h11);
		u_host.xfer(8'h00, rx);
		check(rx, 8'h01);
		check(so, 1'b1);
		// Commands are taken again once the field is out
		u_host.xfer(8'h08, rx);
		u_host.desel();
		check(oth_c, 8'h08);
	endtask : s_restart

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		check(oe, 1'b0);
		check(pin, 1'b1);
		check(rdy_n, 1'b1);
		check(restart, 1'b0);
		repeat (4) @(negedge clk);
		conv = 1'b1;
		s_direct();
		s_rdata();
		s_status();
		s_restart();
		end_sim();
	end

	// Hang guard
	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		end_sim();
	end
endmodule : test_adc_serial_readback

bind adc_serial_readback adc_rb_monitor u_mon (.i_clk, .i_rst_n, .i_cs_n, .i_sclk,
	.i_converting, .i_conv_done, .o_serial_out_with_ready, .o_serial_out_oe,
	.o_result_ready_n, .o_filter_restart, .o_cfg_wr);
